//--- bench/eac_assertions.sv
// port checker for the nonvolatile store controller
`timescale 1ns/1ps
module eac_assertions (
   input wire logic       clk, clk_en, resetn, por_n, osc_clk, global_irq_enable,
   input wire logic       ctrl_wr, addr_wr, data_wr, cpu_stall, ready_irq,
   input wire logic [7:0] ctrl_wdata, ctrl_rdata, addr_wdata, addr_rdata,
   input wire logic [7:0] data_wdata, data_rdata
);
   default clocking cb @(posedge clk); endclocking
   // a frozen clock enable stalls every counter, so timed checks are disabled while it is low
   default disable iff (!resetn || !clk_en);
   // bit 1 of ctrl_rdata is go, bit 2 arm, bits 5:4 mode
   rsvd_zero_a: assert property (ctrl_rdata[7:6] == 2'h0 && !ctrl_rdata[0] && !addr_rdata[7])
      else $error("reserved bits not zero");
   arm_clear_a: assert property (ctrl_wr && ctrl_wdata[2] ##1 (!(ctrl_wr && ctrl_wdata[2]))[*4]
      |=> !ctrl_rdata[2]) else $error("arm not cleared after four cycles");
   go_need_arm_a: assert property (ctrl_wr && ctrl_wdata[1] && !ctrl_rdata[2] && !ctrl_rdata[1]
      |=> !ctrl_rdata[1]) else $error("go taken without arm");
   go_stall_a: assert property (ctrl_wr && ctrl_wdata[1] && ctrl_rdata[2] && !ctrl_rdata[1]
      |=> ctrl_rdata[1] && cpu_stall ##1 cpu_stall ##1 !cpu_stall) else $error("go stall wrong");
   read_stall_a: assert property (ctrl_wr && ctrl_wdata[0] && !ctrl_wdata[1] && !ctrl_rdata[1]
      |=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall wrong");
   addr_frozen_a: assert property (ctrl_rdata[1] && addr_wr |=> $stable(addr_rdata))
      else $error("address changed while busy");
   mode_frozen_a: assert property (ctrl_rdata[1] |=> $stable(ctrl_rdata[5:4]))
      else $error("mode changed while busy");
   ready_level_a: assert property (ready_irq == (ctrl_rdata[3] && global_irq_enable
      && !ctrl_rdata[1])) else $error("ready request level wrong");
   rsvd_go_short_a: assert property (ctrl_rdata[1] && ctrl_rdata[5:4] == 2'h3 |=> !ctrl_rdata[1])
      else $error("reserved mode go not cleared");
endmodule : eac_assertions

bind eac_controller eac_assertions u_chk (.clk(clk), .clk_en(clk_en), .resetn(resetn),
   .por_n(por_n), .osc_clk(osc_clk), .global_irq_enable(global_irq_enable),
   .ctrl_wr(ctrl_wr), .addr_wr(addr_wr), .data_wr(data_wr), .cpu_stall(cpu_stall),
   .ready_irq(ready_irq), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
   .addr_wdata(addr_wdata), .addr_rdata(addr_rdata), .data_wdata(data_wdata),
   .data_rdata(data_rdata));

//--- bench/eac_core_model.sv
// core model issuing register writes to the store controller
`timescale 1ns/1ps
module eac_core_model (
   input  wire logic clk,
   output logic       ctrl_wr, addr_wr, data_wr,
   output logic [7:0] ctrl_wdata, addr_wdata, data_wdata
);
   initial begin
      {ctrl_wr, addr_wr, data_wr} = 3'h0;
      {ctrl_wdata, addr_wdata, data_wdata} = 24'h0;
   end
   // one-cycle strobe; released data lines flip so stale values never look valid
   task automatic put(input int sel, input logic [7:0] v);
      @(posedge clk); #1;
      case (sel)
         0: begin ctrl_wdata = v; ctrl_wr = 1'b1; end
         1: begin addr_wdata = v; addr_wr = 1'b1; end
         default: begin data_wdata = v; data_wr = 1'b1; end
      endcase
      @(posedge clk); #1;
      {ctrl_wr, addr_wr, data_wr} = 3'h0;
      {ctrl_wdata, addr_wdata, data_wdata} = ~{ctrl_wdata, addr_wdata, data_wdata};
   endtask : put
endmodule : eac_core_model

//--- bench/tb.sv
// testbench of the nonvolatile store controller
`timescale 1ns/1ps
module tb;
   import eac_pkg::*;
   localparam int AT_TICKS = 3;
   localparam int SP_TICKS = 2;
   logic       clk = 0, resetn = 0, por_n = 0, osc_clk = 0, gie = 0, clk_en = 1;
   logic       ctrl_wr, addr_wr, data_wr, cpu_stall, ready_irq;
   logic [7:0] ctrl_wdata, addr_wdata, data_wdata, ctrl_rdata, addr_rdata, data_rdata, first_dat;
   logic [8:0] dn;
   int         fails = 0, n_tests = 0, scnt = 0, q_len[$];
   logic [8:0] q_dat[$];
   always #2 clk = ~clk;
   always #18.3 osc_clk = ~osc_clk;
   eac_controller #(.ATOMIC_TICKS_P(AT_TICKS), .SPLIT_TICKS_P(SP_TICKS)) u_dut (.clk(clk),
      .clk_en(clk_en), .resetn(resetn), .por_n(por_n), .osc_clk(osc_clk),
      .global_irq_enable(gie),
      .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .addr_wr(addr_wr),
      .addr_wdata(addr_wdata), .addr_rdata(addr_rdata), .data_wr(data_wr),
      .data_wdata(data_wdata), .data_rdata(data_rdata), .cpu_stall(cpu_stall),
      .ready_irq(ready_irq));
   eac_core_model u_core (.clk(clk), .ctrl_wr(ctrl_wr), .addr_wr(addr_wr), .data_wr(data_wr),
      .ctrl_wdata(ctrl_wdata), .addr_wdata(addr_wdata), .data_wdata(data_wdata));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // address and data loaded before arming, as software must
   task automatic prog(input logic [1:0] m, input logic [6:0] a, input logic [7:0] d);
      int i;
      int nt;
      realtime t0;
      nt = (m == MODE_ATOMIC) ? AT_TICKS : SP_TICKS;
      u_core.put(1, {1'b0, a});
      u_core.put(2, d);
      u_core.put(0, {2'b00, m, gie, 3'b100});
      u_core.put(0, {2'b00, m, gie, 3'b010});
      t0 = $realtime;
      q_len.push_back(2);
      q_dat.push_back(9'h000);
      if (m != MODE_RSVD) begin
         chk("go_busy", 8'h01, {7'h0, ctrl_rdata[1]});
         u_core.put(0, {2'b00, ~m, gie, 3'b001});
         u_core.put(1, {1'b0, ~a});
         chk("mode_held", {6'h0, m}, {6'h0, ctrl_rdata[5:4]});
         chk("addr_held", {1'b0, a}, addr_rdata);
      end
      for (i = 0; i < 300 && ctrl_rdata[1] !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      chk("go_done", 8'h00, {7'h0, ctrl_rdata[1]});
      // busy spans nt oscillator ticks, give or take one period and the sync delay
      if (m != MODE_RSVD) begin
         chk("prog_time", 8'h01, {7'h0, (($realtime - t0) > (nt - 1) * 32.0) &&
             (($realtime - t0) < nt * 36.6 + 24.0)});
      end
   endtask : prog
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      u_core.put(1, {1'b0, a});
      u_core.put(0, {4'h0, gie, 3'b001});
      q_len.push_back(4);
      q_dat.push_back({1'b1, e});
      repeat (6) @(posedge clk);
   endtask : rd
   // stall monitor: each stall burst takes the oldest note
   always @(posedge clk) begin
      if (cpu_stall === 1'b1) begin
         if (scnt == 0) first_dat = data_rdata;
         scnt++;
      end else if (scnt != 0) begin
         if (q_len.size() == 0) chk("stall_note", 8'h00, 8'hFF);
         else begin
            chk("stall_len", 8'(q_len.pop_front()), 8'(scnt));
            dn = q_dat.pop_front();
            if (dn[8]) chk("read_byte", dn[7:0], first_dat);
         end
         scnt = 0;
      end
   end
   initial begin
      #100000;
      fails++;
      end_sim();
   end
   initial begin
      logic [6:0] a;
      logic [7:0] d, d2;
      void'($urandom(32'h2A4B));
      repeat (5) @(posedge clk);
      #1;
      {resetn, por_n} = 2'b11;
      repeat (3) @(posedge clk);
      chk("ctrl_reset", 8'h00, ctrl_rdata);
      chk("addr_reset", 8'h00, addr_rdata);
      $display("test reset done");
      u_core.put(0, 8'hC4);
      chk("arm_set", 8'h04, ctrl_rdata);
      repeat (5) @(posedge clk);
      u_core.put(0, 8'h02);
      chk("go_refused", 8'h00, ctrl_rdata);
      $display("test arm window done");
      u_core.put(0, 8'h04);
      clk_en = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("arm_frozen", 8'h04, ctrl_rdata);
      clk_en = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk("arm_thawed", 8'h00, ctrl_rdata);
      $display("test clock enable done");
      for (int k = 0; k < 4; k++) begin
         gie = k[0];
         a = 7'($urandom());
         d = 8'($urandom());
         d2 = 8'($urandom());
         prog(MODE_ERASE, a, d);
         rd(a, ERASED_BYTE);
         prog(MODE_WRITE, a, d);
         rd(a, d);
         prog(MODE_ATOMIC, a, d2);
         rd(a, d2);
         prog(MODE_RSVD, a, ~d2);
         rd(a, d2);
         chk("ready_idle", {7'h0, k[0]}, {7'h0, ready_irq});
         $display("test program pass %0d done", k);
      end
      // core reset in mid-programming must leave mode and go alone
      u_core.put(0, 8'h04);
      u_core.put(0, 8'h12);
      resetn = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'b1;
      chk("mode_kept", 8'h12, ctrl_rdata);
      repeat (40) @(posedge clk);
      #1;
      chk("kept_done", 8'h10, ctrl_rdata);
      $display("test reset while busy done");
      u_core.put(0, 8'h18);
      resetn = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge clk);
      chk("mode_reset", 8'h00, ctrl_rdata);
      $display("test core reset done");
      end_sim();
   end
endmodule : tb

//--- rtl/eac_controller.sv
// control register, unlock, timing and stall logic of the nonvolatile store
`timescale 1ns/1ps
// What this block does
// - control bits 7..6 are reserved, ignore writes and read zero
// - mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms
// - mode field writes are ignored while program go is set
// - reset clears mode field to 00 unless programming is in progress
// - ready interrupt is a level while enabled, globally enabled and idle
// - program arm clears itself four clock cycles after being written
// - program go starts only while program arm is still set
// - program go stays set during programming, cleared when time elapses, or after one cycle in mode 11
// - accepted program go stalls the core for two cycles
// - read strobe loads the addressed byte into data register at once
// - read strobe stalls the core for four cycles, two when written together with an accepted go
// - during programming read strobes and address writes are blocked
// - no other store operation starts until programming completes
// - erase-only sets the addressed byte to FF ignoring the data register
// - programming time counts calibrated oscillator cycles, not core clock
// - address selects one of 128 bytes, top bit reads zero
// - data register feeds programming and receives read bytes
module eac_controller
   import eac_pkg::*;
#(
   parameter int unsigned ATOMIC_TICKS_P = eac_pkg::ATOMIC_TICKS,
   parameter int unsigned SPLIT_TICKS_P  = eac_pkg::SPLIT_TICKS
) (
   input  wire logic       clk,
   input  wire logic       clk_en,
   input  wire logic       resetn,
   input  wire logic       por_n,
   input  wire logic       osc_clk,
   input  wire logic       global_irq_enable,
   input  wire logic       ctrl_wr,
   input  wire logic [7:0] ctrl_wdata,
   output logic      [7:0] ctrl_rdata,
   input  wire logic       addr_wr,
   input  wire logic [7:0] addr_wdata,
   output logic      [7:0] addr_rdata,
   input  wire logic       data_wr,
   input  wire logic [7:0] data_wdata,
   output logic      [7:0] data_rdata,
   output logic            cpu_stall,
   output logic            ready_irq
);
   import eac_pkg::*;

   if (ATOMIC_TICKS_P < 1 || ATOMIC_TICKS_P >= (1 << TICK_W) ||
       SPLIT_TICKS_P < 1 || SPLIT_TICKS_P >= (1 << TICK_W)) begin : g_chk
      $error("programming tick counts do not fit the timer");
   end

   function automatic logic [TICK_W-1:0] prog_ticks(input eac_mode_e m);
      logic [TICK_W-1:0] t;
      t = TICK_W'(SPLIT_TICKS_P);
      if (m == MODE_ATOMIC) begin
         t = TICK_W'(ATOMIC_TICKS_P);
      end
      return t;
   endfunction : prog_ticks

   // engine state, on power-on reset so a core reset cannot cut programming short
   eac_state_e        state;
   eac_state_e        next_state;
   eac_mode_e         mode;
   eac_mode_e         next_mode;
   logic [TICK_W-1:0] ticks;
   logic [TICK_W-1:0] next_ticks;
   logic              rs1;
   logic              rs2;
   logic              os1;
   logic              os2;
   logic              os3;
   logic              osc_tick;
   logic              go_accept;
   logic              op_fire;
   logic              core_rst_req;

   // core-side state
   logic [2:0]        arm_cnt;
   logic [2:0]        next_arm_cnt;
   logic [2:0]        stall_cnt;
   logic [2:0]        next_stall_cnt;
   logic              rie;
   logic              next_rie;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] next_addr;
   logic [7:0]        data;
   logic [7:0]        next_data;
   logic [7:0]        rd_byte;
   logic              arm;
   logic              busy;
   logic              read_req;

   assign arm          = (arm_cnt != 3'h0);
   assign busy         = (state == ST_PROG);
   assign osc_tick     = os2 & ~os3;
   assign core_rst_req = ~rs2;

   always_comb begin
      next_state = state;
      next_mode  = mode;
      next_ticks = ticks;
      go_accept  = 1'b0;
      op_fire    = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (core_rst_req) begin
               next_mode = MODE_ATOMIC;
            end else if (ctrl_wr) begin
               next_mode = eac_mode_e'(ctrl_wdata[BIT_MODE_HI:BIT_MODE_LO]);
               if (ctrl_wdata[BIT_GO] && arm) begin
                  go_accept  = 1'b1;
                  next_state = ST_PROG;
                  next_ticks = prog_ticks(next_mode);
               end
            end
         end
         ST_PROG: begin
            // mode held here: writes ignored and reset does not clear it
            if (mode == MODE_RSVD) begin
               next_state = ST_IDLE;
            end else if (osc_tick) begin
               if (ticks <= TICK_W'(1)) begin
                  op_fire    = 1'b1;
                  next_state = ST_IDLE;
               end else begin
                  next_ticks = ticks - TICK_W'(1);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         state <= ST_IDLE;
         mode  <= MODE_ATOMIC;
         ticks <= '0;
         rs1   <= 1'b0;
         rs2   <= 1'b0;
         os1   <= 1'b0;
         os2   <= 1'b0;
         os3   <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         mode  <= next_mode;
         ticks <= next_ticks;
         rs1   <= resetn;
         rs2   <= rs1;
         os1   <= osc_clk;
         os2   <= os1;
         os3   <= os2;
      end
   end

   assign read_req = ctrl_wr & ctrl_wdata[BIT_READ] & ~busy;

   always_comb begin
      next_rie       = rie;
      next_addr      = addr;
      next_data      = data;
      next_arm_cnt   = arm_cnt;
      next_stall_cnt = stall_cnt;
      if (ctrl_wr) begin
         next_rie = ctrl_wdata[BIT_RIE];
      end
      if (ctrl_wr && ctrl_wdata[BIT_ARM]) begin
         next_arm_cnt = ARM_CYCLES;
      end else if (arm) begin
         next_arm_cnt = arm_cnt - 3'h1;
      end
      if (addr_wr && !busy) begin
         next_addr = addr_wdata[ADDR_W-1:0];
      end
      if (read_req) begin
         next_data = rd_byte;
      end else if (data_wr) begin
         next_data = data_wdata;
      end
      if (go_accept) begin
         next_stall_cnt = GO_STALL;
      end else if (read_req) begin
         next_stall_cnt = READ_STALL;
      end else if (stall_cnt != 3'h0) begin
         next_stall_cnt = stall_cnt - 3'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rie       <= 1'b0;
         addr      <= '0;
         data      <= RESET_BYTE;
         arm_cnt   <= 3'h0;
         stall_cnt <= 3'h0;
      end else if (clk_en) begin
         rie       <= next_rie;
         addr      <= next_addr;
         data      <= next_data;
         arm_cnt   <= next_arm_cnt;
         stall_cnt <= next_stall_cnt;
      end
   end

   eac_store_array #(
      .DEPTH (STORE_DEPTH)
   ) u_store (
      .clk      (clk),
      .clk_en   (clk_en),
      .op_fire  (op_fire),
      .op_erase (mode != MODE_WRITE),
      .op_write (mode != MODE_ERASE),
      .addr     (addr),
      .wdata    (data),
      .rd_byte  (rd_byte)
   );

   // read strobe is a self-clearing trigger and reads back as zero
   assign ctrl_rdata = {2'b00, mode, rie, arm, busy, 1'b0};
   assign addr_rdata = {1'b0, addr};
   assign data_rdata = data;
   assign cpu_stall  = (stall_cnt != 3'h0);
   assign ready_irq  = rie & global_irq_enable & ~busy;
endmodule : eac_controller

//--- rtl/eac_dummy_unused.sv
// spare file: holds no logic
`timescale 1ns/1ps

//--- rtl/eac_pkg.sv
// constants and types for the nonvolatile store access controller
package eac_pkg;
   localparam int unsigned         ADDR_W          = 7;
   localparam int unsigned         STORE_DEPTH     = 128;
   localparam int unsigned         TICK_W          = 16;
   localparam int unsigned         BIT_READ        = 0;
   localparam int unsigned         BIT_GO          = 1;
   localparam int unsigned         BIT_ARM         = 2;
   localparam int unsigned         BIT_RIE         = 3;
   localparam int unsigned         BIT_MODE_LO     = 4;
   localparam int unsigned         BIT_MODE_HI     = 5;
   localparam logic [2:0]          ARM_CYCLES      = 3'h4;
   localparam logic [2:0]          GO_STALL        = 3'h2;
   localparam logic [2:0]          READ_STALL      = 3'h4;
   localparam logic [7:0]          ERASED_BYTE     = 8'hFF;
   localparam logic [7:0]          RESET_BYTE      = 8'h00;
   localparam int unsigned         OSC_KHZ         = 8000;
   localparam int unsigned         PROG_ATOMIC_US  = 3400;
   localparam int unsigned         PROG_SPLIT_US   = 1800;
   localparam int unsigned         ATOMIC_TICKS    = PROG_ATOMIC_US * OSC_KHZ / 1000;
   localparam int unsigned         SPLIT_TICKS     = PROG_SPLIT_US * OSC_KHZ / 1000;

   typedef enum logic [1:0] {
      MODE_ATOMIC = 2'b00,
      MODE_ERASE  = 2'b01,
      MODE_WRITE  = 2'b10,
      MODE_RSVD   = 2'b11
   } eac_mode_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_PROG = 1'b1
   } eac_state_e;
endpackage : eac_pkg

//--- rtl/eac_store_array.sv
// byte array of the nonvolatile store with erase and program ports
`timescale 1ns/1ps
module eac_store_array
   import eac_pkg::*;
#(
   parameter int unsigned DEPTH = eac_pkg::STORE_DEPTH
) (
   input  wire logic                      clk,
   input  wire logic                      clk_en,
   input  wire logic                      op_fire,
   input  wire logic                      op_erase,
   input  wire logic                      op_write,
   input  wire logic [eac_pkg::ADDR_W-1:0] addr,
   input  wire logic [7:0]                wdata,
   output logic      [7:0]                rd_byte
);
   logic [7:0] cells [DEPTH];
   logic [7:0] next_cell;

   if (DEPTH > (1 << ADDR_W)) begin : g_chk
      $error("store depth exceeds address range");
   end

   assign rd_byte = cells[addr];

   // programming can only clear bits, so write-only onto an unerased cell corrupts it
   always_comb begin
      next_cell = cells[addr];
      if (op_erase) begin
         next_cell = ERASED_BYTE;
      end
      if (op_write) begin
         next_cell = next_cell & wdata;
      end
   end

   // nonvolatile content: no reset
   always_ff @(posedge clk) begin
      if (clk_en && op_fire) begin
         cells[addr] <= next_cell;
      end
   end
endmodule : eac_store_array
